// [rtl/uart_status_pkg.sv]
// Shared constants, register map and carrier types for the transmit/break status block
package uart_status_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0]  ADDR_LINE_STATUS = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h04;
   localparam logic [7:0]  ADDR_LINE_CTRL   = 8'h0c;
   localparam logic [7:0]  ADDR_FIFO_CTRL   = 8'h08;
   localparam logic [7:0]  ADDR_TX_DATA     = 8'h00;
   localparam logic [7:0]  ADDR_RX_DATA     = 8'h00;
   localparam logic [7:0]  ADDR_BAUD_DIV    = 8'h1c;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int TX_ALL_EMPTY_POS   = 6;
   localparam int TX_HOLD_VACANT_POS = 5;
   localparam int LINE_BREAK_POS     = 4;
   localparam int IEN_HOLD_POS       = 1;
   localparam int IEN_LINE_POS       = 2;
   localparam int FIFO_EN_POS        = 0;
   localparam int PARITY_EN_POS      = 3;
   localparam int STOP2_POS          = 2;
   // ****************************************
   // Reset values and sizes
   // ****************************************
   localparam logic [15:0] BAUD_DIV_RESET = 16'h000a;
   localparam logic [7:0]  LINE_CTRL_RESET = 8'h03;
   localparam int          TX_FIFO_DEPTH   = 16;
   localparam int          RX_FIFO_DEPTH   = 16;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic [7:0] awaddr;
      logic [7:0] araddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
   } axil_req_t;
   typedef struct packed {
      logic [7:0] data;
      logic       brk;
   } rx_char_t;
endpackage : uart_status_pkg

// [rtl/bit_timer.sv]
// Bit-period timer: one pulse per programmed bit time while enabled
`timescale 1ns/1ps
module bit_timer
   import uart_status_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic [15:0] divisor,
   output logic             tick
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        tick_next;
   logic        tick_reg;

   always_comb begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (!run) begin
         cnt_next = 16'h0000;
      end else if (cnt_reg + 16'h0001 >= divisor) begin
         cnt_next  = 16'h0000;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule : bit_timer

// [rtl/uart_tx_status.sv]
// Transmit-side empty flags, break detector and AXI4-Lite status registers
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Non-FIFO: all-empty flag high only when holding and shift registers empty
// - FIFO mode: all-empty flag high only when transmit FIFO and shifter empty
// - Reset shows all-empty and hold-vacant as one, break as zero
// - Non-FIFO: hold-vacant clears on load, sets when moved to shifter
// - FIFO mode: hold-vacant clears on any transmit-data write, sets when FIFO drains
// - Interrupt while hold-vacant flag and its enable are both set
// - Break flag set when receive line low longer than one word
// - Word time is start, data, parity and stop bits together
// - Interrupt while break flag and line-status enable are both set
// - Non-FIFO: break flag clears when breaking character is read
// - FIFO mode: break flag follows character at top of receive FIFO
module uart_tx_status
   import uart_status_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output logic [1:0]       S_AXI_BRESP,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   input  wire logic        RXD,
   output logic             TXD,
   output logic             IRQ
);
   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01
   } tx_state_t;

   axil_req_t   req;
   logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
   logic        rv_reg, rv_next;
   logic [7:0]  awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [1:0]  br_reg, br_next, rr_reg, rr_next;
   logic [7:0]  ien_reg, ien_next, lcr_reg, lcr_next, fcr_reg, fcr_next;
   logic [15:0] div_reg, div_next;
   logic [7:0]  txq [TX_FIFO_DEPTH];
   logic [4:0]  tx_cnt_reg, tx_cnt_next;
   logic [3:0]  tx_wp_reg, tx_wp_next, tx_rp_reg, tx_rp_next;
   tx_state_t   st_reg, st_next;
   logic [10:0] sh_reg, sh_next;
   logic [3:0]  sh_bits_reg, sh_bits_next;
   logic        txd_reg, txd_next, irq_reg, irq_next;
   rx_char_t    rxq [RX_FIFO_DEPTH];
   logic [4:0]  rx_cnt_reg, rx_cnt_next;
   logic [3:0]  rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
   logic [3:0]  low_bits_reg, low_bits_next;
   logic        brk_seen_reg, brk_seen_next;
   logic        tick;
   logic        do_wr, do_rd, tx_push, tx_pop, rx_push, rx_pop;
   logic        fifo_mode, hold_vacant, all_empty, line_break;
   logic [3:0]  word_bits;

   assign req.awaddr = S_AXI_AWADDR;
   assign req.araddr = S_AXI_ARADDR;
   assign req.wdata  = S_AXI_WDATA;
   assign req.wstrb  = S_AXI_WSTRB;
   assign fifo_mode  = fcr_reg[FIFO_EN_POS];

   // ****************************************
   // Flags
   // ****************************************
   // One slot in non-FIFO mode: the holding register is the FIFO entry at the read pointer
   assign hold_vacant = (tx_cnt_reg == 5'd0);
   assign all_empty   = hold_vacant && (st_reg == TX_IDLE);
   assign line_break  = (rx_cnt_reg != 5'd0) && rxq[rx_rp_reg].brk;

   // Start + data(5..8) + parity + stop(1/2)
   assign word_bits = 4'd1 + {2'b00, lcr_reg[1:0]} + 4'd5
                    + {3'b000, lcr_reg[PARITY_EN_POS]} + {3'b000, lcr_reg[STOP2_POS]} + 4'd1;

   // ****************************************
   // Bus slave
   // ****************************************
   assign do_wr = aw_reg && w_reg && !bv_reg;
   assign do_rd = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb begin
      aw_next  = aw_reg;
      w_next   = w_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      awa_next = awa_reg;
      wd_next  = wd_reg;
      rv_next  = rv_reg;
      rr_next  = rr_reg;
      rd_next  = rd_reg;
      ien_next = ien_reg;
      lcr_next = lcr_reg;
      fcr_next = fcr_reg;
      div_next = div_reg;
      tx_push  = 1'b0;
      rx_pop   = 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_next  = 1'b1;
         awa_next = req.awaddr;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_next  = 1'b1;
         wd_next = req.wstrb[0] ? req.wdata : 32'h0000_0000;
      end
      if (do_wr) begin
         aw_next = 1'b0;
         w_next  = 1'b0;
         bv_next = 1'b1;
         br_next = RESP_OKAY;
         case (awa_reg)
            ADDR_TX_DATA: begin
               // A full FIFO drops the character; software must check first
               if (tx_cnt_reg < (fifo_mode ? 5'(TX_FIFO_DEPTH) : 5'd1)) begin
                  tx_push = 1'b1;
               end else begin
                  br_next = RESP_SLVERR;
               end
            end
            ADDR_IRQ_ENABLE: ien_next = wd_reg[7:0];
            ADDR_FIFO_CTRL:  fcr_next = wd_reg[7:0];
            ADDR_LINE_CTRL:  lcr_next = wd_reg[7:0];
            ADDR_BAUD_DIV:   div_next = (wd_reg[15:0] == 16'h0000) ? 16'h0001 : wd_reg[15:0];
            default:         br_next = RESP_SLVERR;
         endcase
      end
      if (bv_reg && S_AXI_BREADY) begin
         bv_next = 1'b0;
      end
      if (do_rd) begin
         rv_next = 1'b1;
         rr_next = RESP_OKAY;
         rd_next = 32'h0000_0000;
         case (req.araddr)
            ADDR_RX_DATA: begin
               rd_next[7:0] = (rx_cnt_reg != 5'd0) ? rxq[rx_rp_reg].data : 8'h00;
               rx_pop       = (rx_cnt_reg != 5'd0);
            end
            ADDR_LINE_STATUS: begin
               rd_next[TX_ALL_EMPTY_POS]   = all_empty;
               rd_next[TX_HOLD_VACANT_POS] = hold_vacant;
               rd_next[LINE_BREAK_POS]     = line_break;
               rd_next[0]                  = (rx_cnt_reg != 5'd0);
            end
            ADDR_IRQ_ENABLE: rd_next[7:0]  = ien_reg;
            ADDR_FIFO_CTRL:  rd_next[7:0]  = fcr_reg;
            ADDR_LINE_CTRL:  rd_next[7:0]  = lcr_reg;
            ADDR_BAUD_DIV:   rd_next[15:0] = div_reg;
            default:         rr_next = RESP_SLVERR;
         endcase
      end else if (rv_reg && S_AXI_RREADY) begin
         rv_next = 1'b0;
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   always_comb begin
      st_next      = st_reg;
      sh_next      = sh_reg;
      sh_bits_next = sh_bits_reg;
      txd_next     = txd_reg;
      tx_pop       = 1'b0;
      case (st_reg)
         TX_IDLE: begin
            txd_next = 1'b1;
            if (tx_cnt_reg != 5'd0) begin
               tx_pop       = 1'b1;
               st_next      = TX_SHIFT;
               sh_next      = {2'b11, ^txq[tx_rp_reg], txq[tx_rp_reg]};
               sh_bits_next = word_bits - 4'd1;
               txd_next     = 1'b0;
            end
         end
         TX_SHIFT: begin
            if (tick) begin
               if (sh_bits_reg == 4'd0) begin
                  st_next  = TX_IDLE;
                  txd_next = 1'b1;
               end else begin
                  txd_next     = sh_reg[0];
                  sh_next      = {1'b1, sh_reg[10:1]};
                  sh_bits_next = sh_bits_reg - 4'd1;
               end
            end
         end
         default: st_next = TX_IDLE;
      endcase
   end

   // ****************************************
   // Break detector
   // ****************************************
   // Counting in bit ticks makes the threshold follow the line settings
   always_comb begin
      low_bits_next = low_bits_reg;
      brk_seen_next = brk_seen_reg;
      rx_push       = 1'b0;
      if (RXD) begin
         low_bits_next = 4'd0;
         brk_seen_next = 1'b0;
      end else if (tick && !brk_seen_reg) begin
         if (low_bits_reg >= word_bits) begin
            rx_push       = 1'b1;
            brk_seen_next = 1'b1;
         end else begin
            low_bits_next = low_bits_reg + 4'd1;
         end
      end
      irq_next = (hold_vacant && ien_reg[IEN_HOLD_POS])
               || (line_break && ien_reg[IEN_LINE_POS]);
   end

   bit_timer u_bit_timer (
      .clk     (CLK_SYS),
      .rst     (RESET),
      .run     ((st_reg == TX_SHIFT) || !RXD),
      .divisor (div_reg),
      .tick    (tick)
   );

   // ****************************************
   // Counters and pointers
   // ****************************************
   always_comb begin
      tx_wp_next  = tx_wp_reg + {3'b000, tx_push};
      tx_rp_next  = tx_rp_reg + {3'b000, tx_pop};
      tx_cnt_next = tx_cnt_reg + {4'd0, tx_push} - {4'd0, tx_pop};
      // Non-FIFO mode keeps one slot: a new break overwrites the last one
      rx_wp_next  = rx_wp_reg + {3'b000, rx_push && fifo_mode};
      rx_rp_next  = rx_rp_reg + {3'b000, rx_pop && fifo_mode};
      rx_cnt_next = rx_cnt_reg;
      if (rx_push && (rx_cnt_reg < (fifo_mode ? 5'(RX_FIFO_DEPTH) : 5'd1))) begin
         rx_cnt_next = rx_cnt_reg + 5'd1 - {4'd0, rx_pop};
      end else if (rx_pop && !rx_push) begin
         rx_cnt_next = rx_cnt_reg - 5'd1;
      end
      if (!fifo_mode) begin
         rx_wp_next = 4'd0;
         rx_rp_next = 4'd0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (tx_push) begin
         txq[tx_wp_reg] <= wd_reg[7:0];
      end
      if (rx_push) begin
         rxq[rx_wp_reg] <= '{data: 8'h00, brk: 1'b1};
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         aw_reg       <= 1'b0;
         w_reg        <= 1'b0;
         bv_reg       <= 1'b0;
         br_reg       <= RESP_OKAY;
         awa_reg      <= 8'h00;
         wd_reg       <= 32'h0000_0000;
         rv_reg       <= 1'b0;
         rr_reg       <= RESP_OKAY;
         rd_reg       <= 32'h0000_0000;
         ien_reg      <= 8'h00;
         lcr_reg      <= LINE_CTRL_RESET;
         fcr_reg      <= 8'h00;
         div_reg      <= BAUD_DIV_RESET;
         tx_cnt_reg   <= 5'd0;
         tx_wp_reg    <= 4'd0;
         tx_rp_reg    <= 4'd0;
         st_reg       <= TX_IDLE;
         sh_reg       <= 11'h7ff;
         sh_bits_reg  <= 4'd0;
         txd_reg      <= 1'b1;
         irq_reg      <= 1'b0;
         rx_cnt_reg   <= 5'd0;
         rx_wp_reg    <= 4'd0;
         rx_rp_reg    <= 4'd0;
         low_bits_reg <= 4'd0;
         brk_seen_reg <= 1'b0;
      end else begin
         aw_reg       <= aw_next;
         w_reg        <= w_next;
         bv_reg       <= bv_next;
         br_reg       <= br_next;
         awa_reg      <= awa_next;
         wd_reg       <= wd_next;
         rv_reg       <= rv_next;
         rr_reg       <= rr_next;
         rd_reg       <= rd_next;
         ien_reg      <= ien_next;
         lcr_reg      <= lcr_next;
         fcr_reg      <= fcr_next;
         div_reg      <= div_next;
         tx_cnt_reg   <= tx_cnt_next;
         tx_wp_reg    <= tx_wp_next;
         tx_rp_reg    <= tx_rp_next;
         st_reg       <= st_next;
         sh_reg       <= sh_next;
         sh_bits_reg  <= sh_bits_next;
         txd_reg      <= txd_next;
         irq_reg      <= irq_next;
         rx_cnt_reg   <= rx_cnt_next;
         rx_wp_reg    <= rx_wp_next;
         rx_rp_reg    <= rx_rp_next;
         low_bits_reg <= low_bits_next;
         brk_seen_reg <= brk_seen_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign S_AXI_AWREADY = !aw_reg && !bv_reg;
   assign S_AXI_WREADY  = !w_reg && !bv_reg;
   assign S_AXI_BVALID  = bv_reg;
   assign S_AXI_BRESP   = br_reg;
   assign S_AXI_ARREADY = !rv_reg;
   assign S_AXI_RVALID  = rv_reg;
   assign S_AXI_RDATA   = rd_reg;
   assign S_AXI_RRESP   = rr_reg;
   assign TXD           = txd_reg;
   assign IRQ           = irq_reg;
endmodule : uart_tx_status

// [tb/uart_tx_status_properties.sv]
// Port-level assertions for the transmit and break status block
`timescale 1ns/1ps
module uart_tx_status_checker
   import uart_status_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [7:0]  S_AXI_AWADDR,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        TXD,
   input wire logic        IRQ
);
   // Shadow of the enable bits, taken at the write response so it never leads the design
   logic [7:0] aw_reg, aw_next;
   logic [1:0] wd_reg, wd_next;
   logic [1:0] ien_reg, ien_next;
   logic       stat_reg, stat_next;
   always_comb begin
      aw_next = aw_reg;
      wd_next = wd_reg;
      ien_next = ien_reg;
      stat_next = stat_reg;
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_next = S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY)
         wd_next = {S_AXI_WDATA[IEN_LINE_POS], S_AXI_WDATA[IEN_HOLD_POS]};
      if (S_AXI_BVALID && S_AXI_BREADY && aw_reg == ADDR_IRQ_ENABLE) ien_next = wd_reg;
      if (S_AXI_ARVALID && S_AXI_ARREADY) stat_next = (S_AXI_ARADDR == ADDR_LINE_STATUS);
   end
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         aw_reg <= 8'h00;
         wd_reg <= 2'h0;
         ien_reg <= 2'h0;
         stat_reg <= 1'b0;
      end else begin
         aw_reg <= aw_next;
         wd_reg <= wd_next;
         ien_reg <= ien_next;
         stat_reg <= stat_next;
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped early");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped early");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered next cycle");
   write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("write not answered");
   write_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read taken while data pending");
   status_upper_a: assert property ($rose(S_AXI_RVALID) && stat_reg |->
      S_AXI_RDATA[31:7] == 25'h0) else $error("status upper bits not zero");
   empty_order_a: assert property ($rose(S_AXI_RVALID) && stat_reg |->
      !(S_AXI_RDATA[6] && !S_AXI_RDATA[5])) else $error("all empty without hold vacant");
   busy_line_a: assert property ($rose(S_AXI_RVALID) && stat_reg && !$past(TXD) |->
      !S_AXI_RDATA[6]) else $error("all empty while shifting");
   irq_cause_a: assert property (IRQ |-> ien_reg != 2'h0 || S_AXI_BVALID)
      else $error("interrupt without enable");
   txd_idle_a: assert property ($fell(RESET) |-> TXD)
      else $error("line not idle after reset");
endmodule : uart_tx_status_checker
bind uart_tx_status uart_tx_status_checker uart_tx_status_checker_i (.CLK_SYS, .RESET,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_WDATA, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .TXD, .IRQ);

// [tb/serial_peer.sv]
// Remote serial peer that holds the receive line low on request
`timescale 1ns/1ps
module serial_peer (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] low_len,
   output logic             rxd,
   output logic             busy
);
   // Peer drives the line high itself, so it reads high whenever the peer is quiet
   logic [15:0] cnt = 16'h0000;
   initial rxd = 1'b1;
   initial busy = 1'b0;
   always @(posedge clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         rxd <= 1'b0;
         cnt <= low_len;
      end else if (busy && cnt > 16'h0001) begin
         cnt <= cnt - 16'h0001;
      end else if (busy) begin
         busy <= 1'b0;
         rxd <= 1'b1;
      end
   end
endmodule : serial_peer

// [tb/uart_tx_status_test.sv]
// Self-checking bench for the transmit and break status block
`timescale 1ns/1ps
module uart_tx_status_test
   import uart_status_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        awv = 1'b0;
   logic [7:0]  awa = 8'h00;
   logic        wv  = 1'b0;
   logic [31:0] wd  = 32'h0;
   logic        bry = 1'b0;
   logic        arv = 1'b0;
   logic [7:0]  ara = 8'h00;
   logic        rry = 1'b0;
   logic        go  = 1'b0;
   logic [15:0] low = 16'h0;
   logic        awr, wrdy, bv, arr, rv, rxd, txd, irq, pbusy;
   logic [1:0]  br, rr, r;
   logic [31:0] rdat, d;
   int          n_mismatch = 0;
   int          compares = 0;
   int          errs;
   always #25 clk = ~clk;
   uart_tx_status uart_tx_status_i (.CLK_SYS(clk), .RESET(rst), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
      .RXD(rxd), .TXD(txd), .IRQ(irq));
   serial_peer serial_peer_i (.clk(clk), .go(go), .low_len(low), .rxd(rxd), .busy(pbusy));
   // *****************************
   // Bus, line and check tasks
   // *****************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Trailing idle edge keeps a following call from re-driving a strobe in the same step
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= v;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!bv);
      resp = br;
      bry <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      v = rdat;
      resp = rr;
      rry <= 1'b0;
      @(posedge clk);
   endtask : rd
   task automatic st(input logic [2:0] e);
      rd(ADDR_LINE_STATUS, d, r);
      chk({29'h0, d[TX_ALL_EMPTY_POS], d[TX_HOLD_VACANT_POS], d[LINE_BREAK_POS]}, {29'h0, e});
   endtask : st
   task automatic wait_empty;
      do rd(ADDR_LINE_STATUS, d, r); while (d[TX_ALL_EMPTY_POS] !== 1'b1);
   endtask : wait_empty
   task automatic brk(input logic [15:0] n);
      low <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (pbusy);
      repeat (4) @(posedge clk);
   endtask : brk
   task automatic summarize;
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // *****************************
   // Tests
   // *****************************
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      st(3'b110);
      chk({31'h0, irq}, 32'h0);
      rd(8'h40, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(d, 32'h0);
      wr(ADDR_BAUD_DIV, 32'h4, r);
      wr(ADDR_IRQ_ENABLE, 32'h1 << IEN_HOLD_POS, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_TX_DATA, 32'h55, r);
      chk({31'h0, txd}, 32'h0);
      st(3'b010);
      wr(ADDR_TX_DATA, 32'haa, r);
      st(3'b000);
      chk({31'h0, irq}, 32'h0);
      wait_empty();
      st(3'b110);
      chk({31'h0, txd}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_ENABLE, 32'h0, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Slow bit rate so the whole fill lands inside one frame of the first character
      wr(ADDR_FIFO_CTRL, 32'h1, r);
      wr(ADDR_BAUD_DIV, 32'h10, r);
      errs = 0;
      for (int i = 0; i < 20; i++) begin
         wr(ADDR_TX_DATA, 32'(i), r);
         if (r === RESP_SLVERR) errs++;
      end
      chk(32'(errs), 32'd3);
      st(3'b000);
      wait_empty();
      st(3'b110);
      // Ten bit times low: above a 7-bit word, below a 12-bit word
      wr(ADDR_BAUD_DIV, 32'h4, r);
      wr(ADDR_LINE_CTRL, 32'hf, r);
      brk(16'd40);
      st(3'b110);
      wr(ADDR_LINE_CTRL, 32'h0, r);
      brk(16'd40);
      st(3'b111);
      brk(16'd40);
      wr(ADDR_IRQ_ENABLE, 32'h1 << IEN_LINE_POS, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd(ADDR_RX_DATA, d, r);
      st(3'b111);
      rd(ADDR_RX_DATA, d, r);
      st(3'b110);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_FIFO_CTRL, 32'h0, r);
      brk(16'd40);
      st(3'b111);
      rd(ADDR_RX_DATA, d, r);
      st(3'b110);
      summarize();
   end
endmodule : uart_tx_status_test
